// ===== flash_ctl_pkg.sv
/*
  Constants and types for the flash program/erase control block.
  Assumes a byte-wide register port in the processor clock domain.
*/
package flash_ctl_pkg;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [2:0] OFF_MODE_CTRL  = 3'h0;
  localparam logic [2:0] OFF_ERR_STATUS = 3'h1;
  localparam logic [2:0] OFF_ERASE_BLK  = 3'h2;
  localparam logic [2:0] OFF_ACCESS_EN  = 3'h3;
  localparam logic [2:0] OFF_IRQ_STATUS = 3'h4;
  localparam logic [2:0] OFF_IRQ_MASK   = 3'h5;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_SWE  = 6;
  localparam int BIT_ESU  = 5;
  localparam int BIT_PSU  = 4;
  localparam int BIT_EV   = 3;
  localparam int BIT_PV   = 2;
  localparam int BIT_ERS  = 1;
  localparam int BIT_PRG  = 0;
  localparam int BIT_ERR  = 7;
  localparam int BIT_AEN  = 7;
  localparam int BLK_W    = 5;

  // Interrupt status bits
  localparam int IRQ_ERR  = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_W    = 2;

  // ==========================================================
  // Reset values and masks
  // ==========================================================
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] MODE_WMASK  = 8'h7f;
  localparam logic [7:0] BLK_RST     = 8'h00;
  localparam logic [7:0] ZERO8       = 8'h00;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PSETUP  = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_PVERIFY = 3'b011,
    ST_ESETUP  = 3'b100,
    ST_ERASE   = 3'b101,
    ST_EVERIFY = 3'b110
  } flash_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ===== flash_state_decode.sv
/*
  Derives the flash operating state from the mode control bits.
  Assumes bits come straight from the mode control register.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_state_decode (
  input  wire logic [7:0]                    i_mode,
  output var  flash_ctl_pkg::flash_state_t   o_state
);

  wire soft_write_enable = i_mode[flash_ctl_pkg::BIT_SWE];
  wire erase_setup = i_mode[flash_ctl_pkg::BIT_ESU];
  wire program_setup = i_mode[flash_ctl_pkg::BIT_PSU];
  wire ers = i_mode[flash_ctl_pkg::BIT_ERS];
  wire prg = i_mode[flash_ctl_pkg::BIT_PRG];
  wire ev  = i_mode[flash_ctl_pkg::BIT_EV];
  wire pv  = i_mode[flash_ctl_pkg::BIT_PV];

  // Active operation outranks setup, setup outranks verify
  assign o_state = !soft_write_enable        ? flash_ctl_pkg::ST_IDLE    :
                   (ers && erase_setup) ? flash_ctl_pkg::ST_ERASE   :
                   (prg && program_setup) ? flash_ctl_pkg::ST_PROGRAM :
                   erase_setup          ? flash_ctl_pkg::ST_ESETUP  :
                   program_setup          ? flash_ctl_pkg::ST_PSETUP  :
                   ev           ? flash_ctl_pkg::ST_EVERIFY :
                   pv           ? flash_ctl_pkg::ST_PVERIFY :
                                  flash_ctl_pkg::ST_IDLE;

endmodule
`default_nettype wire

// ===== flash_program_erase_control.sv
/*
  Flash program/erase control and status registers with interrupt.
  Assumes a single-cycle strobed register port on i_clock and a
  flash array that reports error protection on i_error_protect.
*/
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Mode control bit 7 reads zero
// - Program and erase need soft write enable
// - Without write enable, other sets ignored
// - Erase setup bit selects erase setup state
// - Program setup bit selects program setup
// - Erase check bit selects erase verify
// - Program check bit selects program verify
// - Erase needs write enable and erase setup
// - Program needs write enable and program setup
// - Status register is read only
// - Error protection during program or erase sets the error flag
// - Status bits six to zero read zero
// - Block select zero while write enable clear
// - Access gated by control access enable
module flash_program_erase_control (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_error_protect,
  output logic      [7:0] o_rdata,
  output logic            o_program,
  output logic            o_erase,
  output logic            o_prog_verify,
  output logic            o_erase_verify,
  output logic      [4:0] o_erase_blocks,
  output logic            o_irq
);

  // ==========================================================
  // Request bundle and address decode
  // ==========================================================
  flash_ctl_pkg::reg_req_t req;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  logic [7:0] mode_r;
  logic [7:0] blk_r;
  logic       aen_r;
  logic       err_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic [1:0] ep_sync_r;
  logic       op_prev_r;

  function automatic logic hit(input logic [2:0] a,
                               input logic [2:0] off);
    hit = (a == off);
  endfunction

  // Flash control registers reachable only with access enable
  wire ctl_ok  = aen_r;
  wire wr_mode = req.wr && hit(req.addr, flash_ctl_pkg::OFF_MODE_CTRL)
                 && ctl_ok;
  wire wr_blk  = req.wr && hit(req.addr, flash_ctl_pkg::OFF_ERASE_BLK)
                 && ctl_ok;
  wire wr_aen  = req.wr && hit(req.addr, flash_ctl_pkg::OFF_ACCESS_EN);
  wire wr_ist  = req.wr && hit(req.addr, flash_ctl_pkg::OFF_IRQ_STATUS);
  wire wr_msk  = req.wr && hit(req.addr, flash_ctl_pkg::OFF_IRQ_MASK);

  // ==========================================================
  // Mode control next value
  // ==========================================================
  wire        new_swe  = req.wdata[flash_ctl_pkg::BIT_SWE];
  wire [7:0]  wr_val   = req.wdata & flash_ctl_pkg::MODE_WMASK;
  // Without write enable only the enable bit itself may rise
  wire [7:0]  gated    = mode_r[flash_ctl_pkg::BIT_SWE] ? wr_val :
                         (wr_val & (8'h01 << flash_ctl_pkg::BIT_SWE));
  wire [7:0]  mode_nxt = wr_mode ? gated : mode_r;

  // Block select: cleared while enable low, multi-bit write clears
  wire [4:0]  blk_w    = req.wdata[4:0];
  wire        blk_one  = ($countones(blk_w) <= 1);
  wire        swe_now  = mode_nxt[flash_ctl_pkg::BIT_SWE];
  wire [7:0]  blk_nxt  = !swe_now ? flash_ctl_pkg::BLK_RST :
                         (wr_blk && mode_r[flash_ctl_pkg::BIT_SWE])
                           ? (blk_one ? {3'h0, blk_w} : 8'h00)
                           : blk_r;

  // ==========================================================
  // Operating state
  // ==========================================================
  flash_ctl_pkg::flash_state_t state;

  flash_state_decode u_decode (
    .i_mode  (mode_r),
    .o_state (state)
  );

  wire op_active = (state == flash_ctl_pkg::ST_PROGRAM) ||
                   (state == flash_ctl_pkg::ST_ERASE);
  wire err_evt   = ep_sync_r[1] && op_active;
  wire done_evt  = op_prev_r && !op_active;

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_r    <= flash_ctl_pkg::MODE_RST;
      blk_r     <= flash_ctl_pkg::BLK_RST;
      aen_r     <= 1'b0;
      ep_sync_r <= 2'b00;
      op_prev_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      blk_r     <= blk_nxt;
      if (wr_aen) begin
        aen_r <= req.wdata[flash_ctl_pkg::BIT_AEN];
      end
      ep_sync_r <= {ep_sync_r[0], i_error_protect};
      op_prev_r <= op_active;
    end
  end

  // Error flag is sticky; status register takes no write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      err_r <= 1'b0;
    end else if (err_evt) begin
      err_r <= 1'b1;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  wire [1:0] evts    = {done_evt, err_evt};
  wire [1:0] ist_nxt = (irq_stat_r & ~(wr_ist ? req.wdata[1:0] : 2'b00))
                       | evts;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
    end else begin
      irq_stat_r <= ist_nxt;
      if (wr_msk) begin
        irq_mask_r <= req.wdata[1:0];
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================
  // Read path
  // ==========================================================
  wire [7:0] err_byte = {err_r, 7'h00};
  wire [7:0] rd_mux =
    hit(req.addr, flash_ctl_pkg::OFF_MODE_CTRL)
      ? (ctl_ok ? (mode_r & flash_ctl_pkg::MODE_WMASK) : 8'h00) :
    hit(req.addr, flash_ctl_pkg::OFF_ERR_STATUS)
      ? (ctl_ok ? err_byte : 8'h00) :
    hit(req.addr, flash_ctl_pkg::OFF_ERASE_BLK)
      ? (ctl_ok ? blk_r : 8'h00) :
    hit(req.addr, flash_ctl_pkg::OFF_ACCESS_EN)
      ? {aen_r, 7'h00} :
    hit(req.addr, flash_ctl_pkg::OFF_IRQ_STATUS)
      ? {6'h00, irq_stat_r} :
    hit(req.addr, flash_ctl_pkg::OFF_IRQ_MASK)
      ? {6'h00, irq_mask_r} : flash_ctl_pkg::ZERO8;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata        = rdata_r;
  assign o_program      = (state == flash_ctl_pkg::ST_PROGRAM);
  assign o_erase        = (state == flash_ctl_pkg::ST_ERASE);
  assign o_prog_verify  = (state == flash_ctl_pkg::ST_PVERIFY);
  assign o_erase_verify = (state == flash_ctl_pkg::ST_EVERIFY);
  assign o_erase_blocks = blk_r[4:0];

  // ==========================================================
  // Checks
  // ==========================================================
  property p_bit7_zero;
    @(posedge i_clock) disable iff (i_rst)
      !mode_r[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero)
    else $error("mode bit 7 set");

  property p_op_needs_swe;
    @(posedge i_clock) disable iff (i_rst)
      (o_program || o_erase) |-> mode_r[flash_ctl_pkg::BIT_SWE];
  endproperty
  a_op_needs_swe: assert property (p_op_needs_swe)
    else $error("operation without write enable");

  property p_locked;
    @(posedge i_clock) disable iff (i_rst)
      (!mode_r[flash_ctl_pkg::BIT_SWE] && wr_mode && !new_swe)
        |=> (mode_r == 8'h00);
  endproperty
  a_locked: assert property (p_locked)
    else $error("mode bits set while locked");

  property p_esetup;
    @(posedge i_clock) disable iff (i_rst)
      (mode_r[flash_ctl_pkg::BIT_SWE] && mode_r[flash_ctl_pkg::BIT_ESU]
       && !mode_r[flash_ctl_pkg::BIT_ERS]
       && !(mode_r[flash_ctl_pkg::BIT_PSU] && mode_r[flash_ctl_pkg::BIT_PRG]))
        |-> (state == flash_ctl_pkg::ST_ESETUP);
  endproperty
  a_esetup: assert property (p_esetup)
    else $error("erase setup state wrong");

  property p_erase;
    @(posedge i_clock) disable iff (i_rst)
      o_erase |-> (mode_r[flash_ctl_pkg::BIT_ESU]
                   && mode_r[flash_ctl_pkg::BIT_ERS]);
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase without setup");

  property p_program;
    @(posedge i_clock) disable iff (i_rst)
      o_program |-> (mode_r[flash_ctl_pkg::BIT_PSU]
                     && mode_r[flash_ctl_pkg::BIT_PRG]);
  endproperty
  a_program: assert property (p_program)
    else $error("program without setup");

  sequence s_err_seen;
    ep_sync_r[1] && op_active;
  endsequence

  property p_err_flag;
    @(posedge i_clock) disable iff (i_rst)
      s_err_seen |=> err_r [*2];
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error flag not set");

  property p_blk_clear;
    @(posedge i_clock) disable iff (i_rst)
      !mode_r[flash_ctl_pkg::BIT_SWE] |-> (blk_r == 8'h00);
  endproperty
  a_blk_clear: assert property (p_blk_clear)
    else $error("block select not cleared");

  property p_access;
    @(posedge i_clock) disable iff (i_rst)
      (!aen_r && i_wr && hit(i_addr, flash_ctl_pkg::OFF_MODE_CTRL))
        |=> $stable(mode_r);
  endproperty
  a_access: assert property (p_access)
    else $error("write passed without access enable");

  property p_hidden_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && !aen_r
       && (hit(i_addr, flash_ctl_pkg::OFF_MODE_CTRL)
           || hit(i_addr, flash_ctl_pkg::OFF_ERR_STATUS)
           || hit(i_addr, flash_ctl_pkg::OFF_ERASE_BLK)))
        |=> (o_rdata == 8'h00);
  endproperty
  a_hidden_read: assert property (p_hidden_read)
    else $error("control register read without access enable");

  property p_status_rsvd;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && hit(i_addr, flash_ctl_pkg::OFF_ERR_STATUS))
        |=> (o_rdata[6:0] == 7'h00);
  endproperty
  a_status_rsvd: assert property (p_status_rsvd)
    else $error("status reserved bits read nonzero");

  property p_status_ro;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && hit(i_addr, flash_ctl_pkg::OFF_ERR_STATUS) && !err_evt)
        |=> $stable(err_r);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status register changed by a write");

  property p_err_sticky;
    @(posedge i_clock) disable iff (i_rst)
      err_r |=> err_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped");

  property p_irq_set_wins;
    @(posedge i_clock) disable iff (i_rst)
      err_evt |=> irq_stat_r[flash_ctl_pkg::IRQ_ERR];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("error event lost from interrupt status");

  property p_blk_single;
    @(posedge i_clock) disable iff (i_rst)
      ($countones(blk_r) <= 1);
  endproperty
  a_blk_single: assert property (p_blk_single)
    else $error("more than one erase block selected");

endmodule
`default_nettype wire

// ===== tb_flash_program_erase_control.sv
/*
  Self-checking bench for the flash program/erase control block.
  Assumes the design's own assertions and the offsets of flash_ctl_pkg.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_flash_program_erase_control;
  logic       i_clock;
  logic       i_rst;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_error_protect;
  logic [7:0] o_rdata;
  logic       o_program;
  logic       o_erase;
  logic       o_prog_verify;
  logic       o_erase_verify;
  logic [4:0] o_erase_blocks;
  logic       o_irq;
  int         error_cnt;
  int         num_checks;

  flash_program_erase_control u_flash_program_erase_control (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .i_error_protect (i_error_protect),
    .o_rdata         (o_rdata),
    .o_program       (o_program),
    .o_erase         (o_erase),
    .o_prog_verify   (o_prog_verify),
    .o_erase_verify  (o_erase_verify),
    .o_erase_blocks  (o_erase_blocks),
    .o_irq           (o_irq)
  );

  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [2:0] a,
                        input logic [7:0] ex);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, ex, d)
  endtask

  // Order: program, erase, program verify, erase verify
  task automatic out_chk(input string nm, input logic [3:0] ex);
    `CHK(nm, ex, {o_program, o_erase, o_prog_verify, o_erase_verify})
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic sc_gating;
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    wr(flash_ctl_pkg::OFF_ACCESS_EN, 8'h80);
    rd_chk("mode no access", flash_ctl_pkg::OFF_MODE_CTRL, 8'h00);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h3f);
    rd_chk("mode no swe", flash_ctl_pkg::OFF_MODE_CTRL, 8'h00);
    out_chk("out no swe", 4'h0);
    wr(flash_ctl_pkg::OFF_ERASE_BLK, 8'h01);
    rd_chk("blk no swe", flash_ctl_pkg::OFF_ERASE_BLK, 8'h00);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'hc0);
    rd_chk("mode bit7", flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    wr(flash_ctl_pkg::OFF_ACCESS_EN, 8'h00);
    rd_chk("mode hidden", flash_ctl_pkg::OFF_MODE_CTRL, 8'h00);
    wr(flash_ctl_pkg::OFF_ACCESS_EN, 8'h80);
  endtask

  task automatic sc_program;
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h41);
    out_chk("prog no setup", 4'h0);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h50);
    out_chk("prog setup", 4'h0);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h51);
    out_chk("prog on", 4'h8);
    rd_chk("mode prog", flash_ctl_pkg::OFF_MODE_CTRL, 8'h51);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h50);
    out_chk("prog off", 4'h0);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h44);
    out_chk("pverify on", 4'h2);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    out_chk("pverify off", 4'h0);
  endtask

  task automatic sc_erase;
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h60);
    out_chk("erase setup", 4'h0);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h62);
    out_chk("erase on", 4'h4);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h60);
    out_chk("erase off", 4'h0);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h48);
    out_chk("everify on", 4'h1);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    out_chk("everify off", 4'h0);
  endtask

  task automatic sc_blocks;
    wr(flash_ctl_pkg::OFF_ERASE_BLK, 8'h04);
    `CHK("blk one", 5'h04, o_erase_blocks)
    wr(flash_ctl_pkg::OFF_ERASE_BLK, 8'h03);
    `CHK("blk two", 5'h00, o_erase_blocks)
    wr(flash_ctl_pkg::OFF_ERASE_BLK, 8'h10);
    `CHK("blk top", 5'h10, o_erase_blocks)
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h00);
    `CHK("blk swe off", 5'h00, o_erase_blocks)
    rd_chk("blk read", flash_ctl_pkg::OFF_ERASE_BLK, 8'h00);
  endtask

  task automatic sc_error;
    logic [7:0] d;
    int         n;
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    wr(flash_ctl_pkg::OFF_IRQ_MASK, 8'h01);
    i_error_protect <= 1'b1;
    repeat (6) @(posedge i_clock);
    rd_chk("err idle", flash_ctl_pkg::OFF_ERR_STATUS, 8'h00);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h50);
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h51);
    n = 0;
    while (o_irq !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    // Timeout counts a mismatch; main sequence then reports
    if (o_irq !== 1'b1) begin
      error_cnt++;
      return;
    end
    rd_chk("err set", flash_ctl_pkg::OFF_ERR_STATUS, 8'h80);
    i_error_protect <= 1'b0;
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h50);
    wr(flash_ctl_pkg::OFF_IRQ_MASK, 8'h00);
    `CHK("irq masked", 1'b0, o_irq)
    wr(flash_ctl_pkg::OFF_IRQ_MASK, 8'h01);
    `CHK("irq unmasked", 1'b1, o_irq)
    repeat (4) @(posedge i_clock);
    rd_chk("irq both", flash_ctl_pkg::OFF_IRQ_STATUS, 8'h03);
    wr(flash_ctl_pkg::OFF_IRQ_STATUS, 8'h03);
    rd(flash_ctl_pkg::OFF_IRQ_STATUS, d);
    `CHK("irq cleared", 8'h00, d)
    `CHK("irq low", 1'b0, o_irq)
    wr(flash_ctl_pkg::OFF_ERR_STATUS, 8'h7f);
    rd_chk("err sticky ro", flash_ctl_pkg::OFF_ERR_STATUS, 8'h80);
    rd_chk("err rsvd", flash_ctl_pkg::OFF_ERR_STATUS, 8'h80);
  endtask

  // ==========================================================
  // Clock, reset and main sequence
  // ==========================================================
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    error_cnt       = 0;
    num_checks      = 0;
    i_rst           = 1'b1;
    i_addr          = 3'h0;
    i_wdata         = 8'h00;
    i_wr            = 1'b0;
    i_rd            = 1'b0;
    i_error_protect = 1'b0;
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    out_chk("reset out", 4'h0);
    `CHK("reset irq", 1'b0, o_irq)
    sc_gating();
    sc_program();
    sc_erase();
    wr(flash_ctl_pkg::OFF_MODE_CTRL, 8'h40);
    sc_blocks();
    sc_error();
    report_and_stop();
  end
endmodule

`default_nettype wire
